// ==== verilog/prc_timer_regs.sv ====
// Purpose: Register map and two-channel input capture of an 8-bit reload timer.
// Assumes: AXI4-Lite master; counter_value and ovf_event come from the counter.
// Notes: Register byte address is four times the register index.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module prc_timer_regs
  import prc_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic [1:0] capture_input_pin,
  input wire logic [7:0] counter_value,
  input wire logic ovf_event,
  output prc_timer_cfg_s timer_cfg,
  output logic force_reload,
  output logic [1:0] capture_irq_req,
  output logic irq
);

  typedef struct packed {
    prc_timer_cfg_s cfg;
    logic force_reload;
    logic [1:0] capture_sens;
    logic [1:0] capture_irq_enable;
    logic [1:0] capture_flag;
    logic [1:0][7:0] capture_value;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic aw_have;
    logic aw_ok;
    logic [7:0] aw_idx;
    logic w_have;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } prc_state_s;

  prc_state_s s_q;
  prc_state_s s_d;
  logic [1:0] capture;
  logic rd_take;
  logic rd_ok;
  logic [7:0] rd_idx;

  // Maps a byte address to a register index; the flag is low if unmapped.
  function automatic logic [8:0] prc_decode(input logic [ADDR_W-1:0] addr);
    logic [7:0] idx;
    logic ok;
    idx = addr[9:2];
    ok = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:10] == '0) &&
      (idx >= IDX_DUTY3) && (idx <= IDX_IRQ_MASK);
    return {ok, idx};
  endfunction : prc_decode

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_chan
      prc_capture_chan u_chan (
        .clk(clk),
        .reset(reset),
        .capture_input_pin(capture_input_pin[g]),
        .rise_sel(s_q.capture_sens[g]),
        .blocked(s_q.capture_flag[g]),
        .capture(capture[g])
      );
    end
  endgenerate

  assign s_axi_awready = ~s_q.aw_have & ~s_q.bvalid;
  assign s_axi_wready = ~s_q.w_have & ~s_q.bvalid;
  assign s_axi_arready = ~s_q.rvalid;
  assign rd_take = s_axi_arvalid & s_axi_arready;
  assign {rd_ok, rd_idx} = prc_decode(s_axi_araddr);

  always_comb
  begin
    s_d = s_q;
    s_d.force_reload = 1'b0;

    if (s_axi_awvalid && s_axi_awready)
    begin
      s_d.aw_have = 1'b1;
      {s_d.aw_ok, s_d.aw_idx} = prc_decode(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata[7:0];
      s_d.w_lane0 = s_axi_wstrb[0];
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end

    // Write commits once both address and data are held.
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid)
    begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = s_q.aw_ok ? RESP_OKAY : RESP_SLVERR;
      if (s_q.aw_ok && s_q.w_lane0)
      begin
        if (s_q.aw_idx == IDX_DUTY3)
        begin
          s_d.cfg.duty[3] = s_q.w_data;
        end
        else if (s_q.aw_idx == IDX_DUTY2)
        begin
          s_d.cfg.duty[2] = s_q.w_data;
        end
        else if (s_q.aw_idx == IDX_DUTY1)
        begin
          s_d.cfg.duty[1] = s_q.w_data;
        end
        else if (s_q.aw_idx == IDX_DUTY0)
        begin
          s_d.cfg.duty[0] = s_q.w_data;
        end
        else if (s_q.aw_idx == IDX_PWM_CTRL)
        begin
          s_d.cfg.pwm_ctrl = s_q.w_data;
        end
        else if (s_q.aw_idx == IDX_TIMER_CS)
        begin
          // The force bit is a pulse and the overflow flag is hardware-owned.
          s_d.cfg.timer_cs[7:3] = s_q.w_data[7:3];
          s_d.cfg.timer_cs[1] = s_q.w_data[1];
          s_d.force_reload = s_q.w_data[TCS_FORCE_BIT];
        end
        else if (s_q.aw_idx == IDX_COUNTER_ACCESS)
        begin
          s_d.cfg.counter_access = s_q.w_data;
        end
        else if (s_q.aw_idx == IDX_RELOAD)
        begin
          s_d.cfg.reload = s_q.w_data;
        end
        else if (s_q.aw_idx == IDX_CAPTURE_CS)
        begin
          s_d.capture_sens = s_q.w_data[CCS_SENS_LSB +: 2];
          s_d.capture_irq_enable = s_q.w_data[CCS_IE_LSB +: 2];
        end
        else if (s_q.aw_idx == IDX_IRQ_MASK)
        begin
          s_d.irq_mask = s_q.w_data[IRQ_W-1:0];
        end
      end
    end

    if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end

    // Read data is latched with its side effects in the same cycle.
    if (rd_take)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
      s_d.rdata = REG_RESET;
      if (!rd_ok)
      begin
        s_d.rdata = REG_RESET;
      end
      else if (rd_idx == IDX_DUTY3)
      begin
        s_d.rdata = s_q.cfg.duty[3];
      end
      else if (rd_idx == IDX_DUTY2)
      begin
        s_d.rdata = s_q.cfg.duty[2];
      end
      else if (rd_idx == IDX_DUTY1)
      begin
        s_d.rdata = s_q.cfg.duty[1];
      end
      else if (rd_idx == IDX_DUTY0)
      begin
        s_d.rdata = s_q.cfg.duty[0];
      end
      else if (rd_idx == IDX_PWM_CTRL)
      begin
        s_d.rdata = s_q.cfg.pwm_ctrl;
      end
      else if (rd_idx == IDX_TIMER_CS)
      begin
        s_d.rdata = s_q.cfg.timer_cs;
        s_d.cfg.timer_cs[TCS_OVF_BIT] = 1'b0;
      end
      else if (rd_idx == IDX_COUNTER_ACCESS)
      begin
        s_d.rdata = s_q.cfg.counter_access;
      end
      else if (rd_idx == IDX_RELOAD)
      begin
        s_d.rdata = s_q.cfg.reload;
      end
      else if (rd_idx == IDX_CAPTURE_CS)
      begin
        s_d.rdata = {2'h0, s_q.capture_sens, s_q.capture_irq_enable,
          s_q.capture_flag} & ~CCS_RESERVED_MASK;
      end
      else if (rd_idx == IDX_CAPTURE1)
      begin
        s_d.rdata = s_q.capture_value[0];
        s_d.capture_flag[0] = 1'b0;
      end
      else if (rd_idx == IDX_CAPTURE2)
      begin
        s_d.rdata = s_q.capture_value[1];
        s_d.capture_flag[1] = 1'b0;
      end
      else if (rd_idx == IDX_IRQ_STATUS)
      begin
        s_d.rdata = {{(8-IRQ_W){1'b0}}, s_q.irq_status};
        s_d.irq_status = '0;
      end
      else
      begin
        s_d.rdata = {{(8-IRQ_W){1'b0}}, s_q.irq_mask};
      end
    end

    // Hardware sets come last so that a set wins over a clear.
    for (int i = 0; i < 2; i++)
    begin
      if (capture[i])
      begin
        s_d.capture_value[i] = counter_value;
        s_d.capture_flag[i] = 1'b1;
      end
    end
    if (capture[0])
    begin
      s_d.irq_status[IRQ_CAP1_BIT] = 1'b1;
    end
    if (capture[1])
    begin
      s_d.irq_status[IRQ_CAP2_BIT] = 1'b1;
    end
    if (ovf_event)
    begin
      s_d.cfg.timer_cs[TCS_OVF_BIT] = 1'b1;
      s_d.irq_status[IRQ_OVF_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = {24'h000000, s_q.rdata};
  assign s_axi_rresp = s_q.rresp;
  assign timer_cfg = s_q.cfg;
  assign force_reload = s_q.force_reload;
  // Requests are plain levels from flags so they need no running clock edge.
  assign capture_irq_req = s_q.capture_flag & s_q.capture_irq_enable;
  assign irq = |(s_q.irq_status & s_q.irq_mask);

endmodule : prc_timer_regs

// ==== verilog/prc_pkg.sv ====
// Purpose: Shared constants and types for the PWM reload timer register block.
// Assumes: Byte registers sit at word addresses equal to four times their index.
// Notes: All registers reset to zero.
package prc_pkg;

  localparam logic [7:0] IDX_DUTY3 = 8'h73;
  localparam logic [7:0] IDX_DUTY2 = 8'h74;
  localparam logic [7:0] IDX_DUTY1 = 8'h75;
  localparam logic [7:0] IDX_DUTY0 = 8'h76;
  localparam logic [7:0] IDX_PWM_CTRL = 8'h77;
  localparam logic [7:0] IDX_TIMER_CS = 8'h78;
  localparam logic [7:0] IDX_COUNTER_ACCESS = 8'h79;
  localparam logic [7:0] IDX_RELOAD = 8'h7A;
  localparam logic [7:0] IDX_CAPTURE_CS = 8'h7B;
  localparam logic [7:0] IDX_CAPTURE1 = 8'h7C;
  localparam logic [7:0] IDX_CAPTURE2 = 8'h7D;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h7E;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h7F;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CCS_RESERVED_MASK = 8'hC0;
  localparam int CCS_SENS_LSB = 4;
  localparam int CCS_IE_LSB = 2;
  localparam int CCS_FLAG_LSB = 0;
  localparam int TCS_FORCE_BIT = 2;
  localparam int TCS_OVF_BIT = 0;

  localparam int IRQ_CAP1_BIT = 0;
  localparam int IRQ_CAP2_BIT = 1;
  localparam int IRQ_OVF_BIT = 2;
  localparam int IRQ_W = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0][7:0] duty;
    logic [7:0] pwm_ctrl;
    logic [7:0] timer_cs;
    logic [7:0] counter_access;
    logic [7:0] reload;
  } prc_timer_cfg_s;

endpackage : prc_pkg

// ==== verilog/prc_capture_chan.sv ====
// Purpose: One capture channel: pin synchroniser and selected-edge detector.
// Assumes: The pin is asynchronous to clk.
// Notes: The capture pulse is suppressed while the channel is blocked.
`timescale 1ns/1ps
module prc_capture_chan
  import prc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic capture_input_pin,
  input wire logic rise_sel,
  input wire logic blocked,
  output logic capture
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
  } prc_chan_state_s;

  prc_chan_state_s s_q;
  prc_chan_state_s s_d;
  logic rise_edge;
  logic fall_edge;

  always_comb
  begin
    s_d = s_q;
    s_d.sync1 = capture_input_pin;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Edges are found on the synchronised level only.
  assign rise_edge = s_q.sync2 & ~s_q.prev;
  assign fall_edge = ~s_q.sync2 & s_q.prev;
  assign capture = (rise_sel ? rise_edge : fall_edge) & ~blocked;

endmodule : prc_capture_chan

// ==== verif/prc_pin_model.sv ====
// Purpose: Drives the two capture pins like an outside source.
// Assumes: The bench sets level right after a clock edge.
// Notes: Pins follow level 7 ns later, off the clock edge.
`timescale 1ns/1ps
module prc_pin_model
(
  input wire logic [1:0] level,
  output wire logic [1:0] capture_input_pin
);
  assign #7 capture_input_pin = level;
endmodule : prc_pin_model

// ==== verif/prc_timer_regs_monitor.sv ====
// Purpose: Port checks for the reload timer register block.
// Assumes: Bound to every prc_timer_regs.
// Notes: One clock domain.
`timescale 1ns/1ps
module prc_timer_regs_monitor
  import prc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] capture_input_pin,
  input wire logic force_reload,
  input wire logic [1:0] capture_irq_req,
  input wire logic irq
);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (reset);
  reset_zero_a: assert property ($fell(reset) |-> !irq && capture_irq_req == 2'h0)
    else $error("request not clear after reset");
  cap_delay_a: assert property ($rose(capture_irq_req[0]) |-> s_axi_bvalid ||
    $past(capture_input_pin[0], 3) != $past(capture_input_pin[0], 4))
    else $error("capture request without synchronised edge");
  req_hold_a: assert property ($fell(capture_irq_req[0]) |->
    s_axi_rvalid || $past(s_axi_rvalid) || s_axi_bvalid)
    else $error("capture request dropped without access");
  bresp_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  rresp_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken while response pending");
  rdata_high_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  force_pulse_a: assert property (force_reload |=> !force_reload)
    else $error("reload pulse too long");
  cap0_c: cover property ($rose(capture_irq_req[0]));
  cap1_c: cover property ($rose(capture_irq_req[1]));
  irq_c: cover property ($rose(irq));
endmodule : prc_timer_regs_monitor

bind prc_timer_regs prc_timer_regs_monitor mon_u (.*);

// ==== verif/prc_timer_regs_tb_top.sv ====
// Purpose: Self-checking bench for prc_timer_regs.
// Assumes: Capture pins come from prc_pin_model.
// Notes: LFSR stimulus seeded with 32'h42EB.
`timescale 1ns/1ps
module prc_timer_regs_tb_top
  import prc_pkg::*;
;
  logic clk, reset, awvalid, awready, wvalid, wready, bvalid, bready, frl, irq, ovf;
  logic arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [1:0] bresp, rresp, lvl, pin, req;
  logic [7:0] cnt, v, cs;
  prc_timer_cfg_s cfg;
  int n_errors, checks, cyc, n_frl;
  prc_timer_regs #(.ADDR_W(12)) dut_u (.clk(clk), .reset(reset),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .capture_input_pin(pin), .counter_value(cnt), .ovf_event(ovf),
    .timer_cfg(cfg), .force_reload(frl), .capture_irq_req(req), .irq(irq));
  prc_pin_model pin_u (.level(lvl), .capture_input_pin(pin));
  // Counts reload pulses away from the edge that launches them.
  always @(negedge clk)
  begin
    if (frl === 1'b1)
      n_frl++;
  end
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Expected capture control/status word for one enabled channel.
  function automatic logic [31:0] ccs_exp(input int ch, input logic rise, flag);
    logic [7:0] b;
    b = 8'h00;
    b[CCS_SENS_LSB + ch] = rise;
    b[CCS_IE_LSB + ch] = 1'b1;
    b[CCS_FLAG_LSB + ch] = flag;
    return {24'h0, b};
  endfunction : ccs_exp
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic xfer(input logic w, input logic [7:0] idx, d, input logic [31:0] exp,
    input logic [1:0] er);
    logic a, b, done;
    logic [31:0] got;
    logic [1:0] r;
    done = 1'b0;
    awaddr <= {2'h0, idx, 2'h0};
    araddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    {awvalid, wvalid, bready, arvalid, rready} <= w ? 5'h1C : 5'h03;
    while (!done)
    begin
      @(negedge clk);
      a = w ? awvalid && awready : arvalid && arready;
      b = wvalid && wready;
      done = w ? bvalid : rvalid;
      got = rdata;
      r = w ? bresp : rresp;
      @(posedge clk);
      if (a)
        {awvalid, arvalid} <= 2'h0;
      if (b)
        wvalid <= 1'b0;
    end
    {bready, rready} <= 2'h0;
    @(posedge clk);
    if (!w)
      chk(got, exp);
    chk({30'h0, r}, {30'h0, er});
  endtask : xfer
  initial
  begin
    {reset, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata, lvl, cnt, ovf} = '0;
    seed = 32'h42EB;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 8'h73; i < 8'h81; i++)
      xfer(1'b0, 8'(i), 8'h00, 0, i > 8'h7F ? RESP_SLVERR : RESP_OKAY);
    xfer(1'b1, 8'h90, 8'h11, 0, RESP_SLVERR);
    $display("reset test done");
    for (int i = 8'h73; i < 8'h7B; i++)
    begin
      if (i == 8'h78)
        continue;
      seed = lfsr(seed);
      v = seed[7:0];
      xfer(1'b1, 8'(i), v, 0, RESP_OKAY);
      xfer(1'b0, 8'(i), 8'h00, {24'h0, v}, RESP_OKAY);
    end
    chk({24'h0, cfg.reload}, {24'h0, v});
    xfer(1'b1, IDX_TIMER_CS, 8'h04, 0, RESP_OKAY);
    chk(n_frl, 1);
    xfer(1'b0, IDX_TIMER_CS, 8'h00, 0, RESP_OKAY);
    xfer(1'b1, IDX_IRQ_MASK, 8'h03, 0, RESP_OKAY);
    ovf <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
    @(posedge clk);
    xfer(1'b0, IDX_TIMER_CS, 8'h00, 32'h1 << TCS_OVF_BIT, RESP_OKAY);
    xfer(1'b0, IDX_TIMER_CS, 8'h00, 0, RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b0, IDX_IRQ_STATUS, 8'h00, 32'h1 << IRQ_OVF_BIT, RESP_OKAY);
    chk(n_frl, 1);
    $display("register test done");
    for (int ch = 0; ch < 2; ch++)
      for (int e = 0; e < 2; e++)
      begin
        cs = 8'(ccs_exp(ch, e[0], 1'b0));
        xfer(1'b1, IDX_CAPTURE_CS, cs, 0, RESP_OKAY);
        lvl[ch] <= !e[0];
        repeat (6) @(posedge clk);
        xfer(1'b0, IDX_CAPTURE_CS, 8'h00, ccs_exp(ch, e[0], 1'b0), RESP_OKAY);
        seed = lfsr(seed);
        v = seed[7:0];
        cnt <= v;
        lvl[ch] <= e[0];
        repeat (6) @(posedge clk);
        chk({30'h0, req}, {30'h0, 2'h1 << ch});
        chk({31'h0, irq}, 32'h1);
        xfer(1'b0, IDX_CAPTURE_CS, 8'h00, ccs_exp(ch, e[0], 1'b1), RESP_OKAY);
        cnt <= ~v;
        lvl[ch] <= !e[0];
        repeat (6) @(posedge clk);
        lvl[ch] <= e[0];
        repeat (6) @(posedge clk);
        xfer(1'b1, IDX_CAPTURE1 + 8'(ch), ~v, 0, RESP_OKAY);
        xfer(1'b0, IDX_CAPTURE1 + 8'(ch), 8'h00, {24'h0, v}, RESP_OKAY);
        xfer(1'b0, IDX_CAPTURE_CS, 8'h00, ccs_exp(ch, e[0], 1'b0), RESP_OKAY);
        xfer(1'b0, IDX_IRQ_STATUS, 8'h00, {30'h0, 2'h1 << ch}, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        $display("capture test %0d %0d done", ch, e);
      end
    xfer(1'b1, IDX_CAPTURE_CS, 8'hFF, 0, RESP_OKAY);
    xfer(1'b0, IDX_CAPTURE_CS, 8'h00, 32'h3C, RESP_OKAY);
    $display("reserved test done");
    give_verdict();
  end
endmodule : prc_timer_regs_tb_top
